/* hw/pmg_defines.vh */
// constants for the physical memory guard register set
`ifndef PMG_DEFINES_VH
`define PMG_DEFINES_VH
`define PMG_CFG_R       0
`define PMG_CFG_W       1
`define PMG_CFG_X       2
`define PMG_CFG_A_LO    3
`define PMG_CFG_A_HI    4
`define PMG_CFG_L       7
`define PMG_CFG_MASK    8'h9f
`define PMG_A_OFF       2'h0
`define PMG_A_TOR       2'h1
`define PMG_A_NA4       2'h2
`define PMG_A_POW2_ALIGNED_BLOCK     2'h3
`define PMG_SEL_CFG     1'b0
`define PMG_SEL_ADDR    1'b1
`define PMG_PRV_U       2'h0
`define PMG_PRV_S       2'h1
`define PMG_PRV_M       2'h3
`define PMG_ACC_FETCH   2'h0
`define PMG_ACC_LOAD    2'h1
`define PMG_ACC_STORE   2'h2
`define PMG_CFG_RESET   8'h00
`define PMG_ADDR_RESET  32'h00000000
`endif

/* hw/pmg_regs.v */
// physical memory guard: entry registers, region matcher and fault check
`include "pmg_defines.vh"

// Notes on behaviour
// - zero, 16 or 64 entries, lowest-numbered ones implemented first.
// - registers reachable only from machine mode; fields write-any, read-legal.
// - 32-bit base packs four config bytes per word, words 0 to 15.
// - 64-bit base has only even config words, eight bytes each; odd illegal.
// - address registers hold physical bits 33:2, or 55:2 on 64-bit base.
// - byte layout: read 0, write 1, execute 2, mode 4:3, zero 6:5, lock 7.
// - set permit allows, clear denies; read-clear write-set never retained.
// - missing execute, read or write permit raises fetch, load, store fault.
// - mode 0 off, 1 range top, 2 four-byte, 3 power-of-two block.
// - power-of-two size from trailing ones: none is 8 bytes, each doubles.
// - range top matches previous address up to own; entry 0 from zero.
// - range top with lower bound not below upper matches nothing.
// - grain is 2^(G+2) bytes for all entries; G>=1 forbids four-byte.
// - G>=2 block reads low ones; off or range top reads low zeros.
// - mode change alters only the read view; stored bits stay.
// - address values are zero-extended to current width before comparing.
// - locked entry ignores writes; range top lock guards previous address too.
// - lock freezes an entry even when its mode is off.
// - locked entries enforce in all modes; unlocked let machine mode pass.
// - lowest matching entry decides; partial cover of the access fails.
// - no match: machine passes, supervisor or user fail if entries exist.
// - checks follow effective privilege, including walks and modified mode.
module pmg_regs #(
    parameter NENT = 16,
    parameter XW   = 32,
    parameter G    = 0
) (
    input  wire            CLK,
    input  wire            NRST,
    input  wire            REG_EN,
    input  wire            REG_WE,
    input  wire            REG_SEL,
    input  wire [5:0]      REG_IDX,
    input  wire [XW-1:0]   REG_WDATA,
    input  wire [1:0]      REG_PRV,
    output reg  [XW-1:0]   REG_RDATA,
    output reg             REG_ILLEGAL,
    input  wire            CHK_VALID,
    input  wire [XW+1:0]   CHK_ADDR,
    input  wire [3:0]      CHK_SIZE,
    input  wire [1:0]      CHK_TYPE,
    input  wire [1:0]      CHK_PRV,
    output reg             FAULT_FETCH,
    output reg             FAULT_LOAD,
    output reg             FAULT_STORE
);
    // address register width follows the base; compares add two low bits
    localparam AW  = (XW == 64) ? 54 : 32;
    localparam BPW = XW / 8;
    localparam NE  = (NENT >= 64) ? 64 : (NENT >= 16) ? 16 : 0;
    localparam NS  = (NE == 0) ? 1 : NE;
    localparam PA  = AW + 2;

    reg  [7:0]    cfg_q  [0:NS-1];
    reg  [AW-1:0] addr_q [0:NS-1];
    wire [1:0]    mode   [0:NS-1];
    wire [NS-1:0] hit, full;
    wire [PA-1:0] acc_lo, acc_hi;

    // end is start plus size less one; nothing clamps it, so oversize accesses wrap
    assign acc_lo = CHK_ADDR[PA-1:0];
    assign acc_hi = acc_lo + {{(PA-4){1'b0}}, CHK_SIZE}
                  - {{(PA-1){1'b0}}, 1'b1};

    // legalise a config byte before storing it
    function [7:0] legal_cfg;
        input [7:0] v;
        input [7:0] old;
        reg   [7:0] t;
        begin
            t = v & `PMG_CFG_MASK;
            if (G >= 1 && t[4:3] == `PMG_A_NA4) begin
                t[4:3] = old[4:3];
            end
            if (!t[`PMG_CFG_R] && t[`PMG_CFG_W]) begin
                t[2:0] = old[2:0];
            end
            legal_cfg = t;
        end
    endfunction

    // read view: low bits depend on mode, store is untouched
    function [AW-1:0] view_addr;
        input [AW-1:0] a;
        input [1:0]    m;
        integer        b;
        begin
            view_addr = a;
            for (b = 0; b < AW; b = b + 1) begin
                if (m[1] && G >= 2 && b <= G - 2) begin
                    view_addr[b] = 1'b1;
                end
                if (!m[1] && G >= 1 && b <= G - 1) begin
                    view_addr[b] = 1'b0;
                end
            end
        end
    endfunction

    // entry i may take an address write unless it or a tor successor is locked
    function addr_wr_ok;
        input integer i;
        begin
            addr_wr_ok = !cfg_q[i][`PMG_CFG_L];
            if (i + 1 < NE) begin
                if (cfg_q[i+1][`PMG_CFG_L] &&
                    cfg_q[i+1][4:3] == `PMG_A_TOR) begin
                    addr_wr_ok = 1'b0;
                end
            end
        end
    endfunction

    wire acc_m   = (REG_PRV == `PMG_PRV_M);
    wire odd_cfg = (XW == 64) && REG_IDX[0] && (REG_SEL == `PMG_SEL_CFG);
    wire bad_idx = (REG_SEL == `PMG_SEL_CFG) ? (REG_IDX > 6'h0f) : 1'b0;
    wire illegal = REG_EN && (!acc_m || odd_cfg || bad_idx);

    // a refused access never writes
    wire wr_ok   = REG_EN && REG_WE && !illegal && (NE != 0);
    wire cfg_wr  = wr_ok && (REG_SEL == `PMG_SEL_CFG);
    wire addr_wr = wr_ok && (REG_SEL == `PMG_SEL_ADDR);

    integer i, k;
    always @(posedge CLK) begin
        if (!NRST) begin
            for (i = 0; i < NS; i = i + 1) begin
                cfg_q[i] <= `PMG_CFG_RESET;
            end
        end else if (cfg_wr) begin
            for (k = 0; k < BPW; k = k + 1) begin
                i = REG_IDX[3:0] * 4 + k;
                // locked bytes keep their value until hart reset
                if (i < NE && !cfg_q[i][`PMG_CFG_L]) begin
                    cfg_q[i] <= legal_cfg(REG_WDATA[k*8 +: 8], cfg_q[i]);
                end
            end
        end
    end

    integer m;
    always @(posedge CLK) begin
        if (!NRST) begin
            for (m = 0; m < NS; m = m + 1) begin
                addr_q[m] <= `PMG_ADDR_RESET;
            end
        end else if (addr_wr) begin
            m = REG_IDX;
            if (m < NE && addr_wr_ok(m)) begin
                addr_q[m] <= REG_WDATA[AW-1:0];
            end
        end
    end

    reg [XW-1:0] rd_d;
    integer      ri, rk;
    always @* begin
        rd_d = {XW{1'b0}};
        ri   = 0;
        if (REG_SEL == `PMG_SEL_CFG) begin
            for (rk = 0; rk < BPW; rk = rk + 1) begin
                ri = REG_IDX[3:0] * 4 + rk;
                if (ri < NE) begin
                    rd_d[rk*8 +: 8] = cfg_q[ri];
                end
            end
        end else begin
            ri = REG_IDX;
            if (ri < NE) begin
                rd_d[AW-1:0] = view_addr(addr_q[ri], cfg_q[ri][4:3]);
            end
        end
        // refused reads show zero rather than leak entry state
        if (illegal) begin
            rd_d = {XW{1'b0}};
        end
    end

    always @(posedge CLK) begin
        if (!NRST) begin
            REG_RDATA   <= {XW{1'b0}};
            REG_ILLEGAL <= 1'b0;
        end else begin
            REG_RDATA   <= rd_d;
            REG_ILLEGAL <= illegal;
        end
    end

    genvar e;
    generate
        for (e = 0; e < NS; e = e + 1) begin : g_ent
            wire [PA-1:0] top, bot, msk, base;
            wire [AW-1:0] a_eff, p_eff, ones;
            assign mode[e] = (NE == 0) ? `PMG_A_OFF : cfg_q[e][4:3];
            // grain bits do not take part in range compares
            assign a_eff = (G >= 1) ? (addr_q[e] >> G) << G : addr_q[e];
            if (e == 0) begin : g_z
                assign p_eff = {AW{1'b0}};
            end else begin : g_p
                assign p_eff = (G >= 1) ? (addr_q[e-1] >> G) << G
                                        : addr_q[e-1];
            end
            // compare space is the address register width plus two zero low bits
            assign top = {a_eff, 2'b00};
            assign bot = {p_eff, 2'b00};
            // trailing ones mark the power-of-two size
            assign ones = view_addr(addr_q[e], `PMG_A_POW2_ALIGNED_BLOCK) ^
                          (view_addr(addr_q[e], `PMG_A_POW2_ALIGNED_BLOCK) + 1'b1);
            assign msk  = (mode[e] == `PMG_A_NA4) ? {{(PA-2){1'b0}}, 2'b11}
                        : {ones, 2'b11};
            assign base = {view_addr(addr_q[e], `PMG_A_POW2_ALIGNED_BLOCK), 2'b00} & ~msk;

            // range top: any byte inside hits, all bytes inside is full
            wire tor_hit  = (bot < top) && (acc_hi >= bot) && (acc_lo < top);
            wire tor_full = (acc_lo >= bot) && (acc_hi < top);
            wire blk_lo   = ((acc_lo & ~msk) == base);
            wire blk_hi   = ((acc_hi & ~msk) == base);

            // off never hits; block modes hit when either end is inside
            assign hit[e] = (mode[e] == `PMG_A_TOR) ? tor_hit
                          : (mode[e] == `PMG_A_OFF) ? 1'b0
                          : (blk_lo || blk_hi);
            assign full[e] = (mode[e] == `PMG_A_TOR) ? tor_full
                           : (blk_lo && blk_hi);
        end
    endgenerate

    // lowest-numbered hit decides; scan runs downward so it is seen last
    reg          found;
    reg          pass_d;
    reg  [7:0]   win;
    integer      j;
    always @* begin
        found  = 1'b0;
        win    = 8'h00;
        pass_d = 1'b1;
        for (j = NS - 1; j >= 0; j = j - 1) begin
            if (hit[j] && NE != 0) begin
                found = 1'b1;
                if (full[j]) begin
                    win = cfg_q[j];
                end else begin
                    // partial cover: locked with no permits, fails in any mode
                    win = 8'h80;
                end
            end
        end
        if (!found) begin
            // no entries at all means nothing is guarded
            pass_d = (CHK_PRV == `PMG_PRV_M) || (NE == 0);
        end else if (!win[`PMG_CFG_L] && CHK_PRV == `PMG_PRV_M) begin
            pass_d = 1'b1;
        end else begin
            case (CHK_TYPE)
                `PMG_ACC_FETCH: pass_d = win[`PMG_CFG_X];
                `PMG_ACC_LOAD:  pass_d = win[`PMG_CFG_R];
                `PMG_ACC_STORE: pass_d = win[`PMG_CFG_W];
                default:        pass_d = 1'b0;
            endcase
        end
    end

    // one fault line per access type, only for a request in this cycle
    reg [2:0] fault_d;
    always @* begin
        fault_d = 3'b000;
        if (CHK_VALID && !pass_d) begin
            case (CHK_TYPE)
                `PMG_ACC_FETCH: fault_d = 3'b100;
                `PMG_ACC_LOAD:  fault_d = 3'b010;
                `PMG_ACC_STORE: fault_d = 3'b001;
                default:        fault_d = 3'b000;
            endcase
        end
    end

    always @(posedge CLK) begin
        if (!NRST) begin
            FAULT_FETCH <= 1'b0;
            FAULT_LOAD  <= 1'b0;
            FAULT_STORE <= 1'b0;
        end else begin
            FAULT_FETCH <= fault_d[2];
            FAULT_LOAD  <= fault_d[1];
            FAULT_STORE <= fault_d[0];
        end
    end
endmodule // pmg_regs

/* tb/pmg_monitor.sv */
// concurrent checks on the memory guard ports
module pmg_monitor #(
    parameter XW = 32
) (
    input wire          CLK,
    input wire          NRST,
    input wire          REG_EN,
    input wire          REG_SEL,
    input wire [5:0]    REG_IDX,
    input wire [1:0]    REG_PRV,
    input wire [XW-1:0] REG_RDATA,
    input wire          REG_ILLEGAL,
    input wire          CHK_VALID,
    input wire [1:0]    CHK_TYPE,
    input wire          FAULT_FETCH,
    input wire          FAULT_LOAD,
    input wire          FAULT_STORE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    prv_refuse_a: assert property (REG_EN && REG_PRV != 2'h3
        |=> REG_ILLEGAL) else $error("low privilege access accepted");
    idx_refuse_a: assert property (REG_EN && !REG_SEL
        && REG_IDX > 6'd15 |=> REG_ILLEGAL) else $error("bad index accepted");
    legal_ok_a: assert property (REG_EN && REG_PRV == 2'h3
        && (REG_SEL || REG_IDX < 6'd16) |=> !REG_ILLEGAL)
        else $error("legal access refused");
    ill_zero_a: assert property (REG_ILLEGAL |-> REG_RDATA == 0)
        else $error("refused access returned data");
    fetch_only_a: assert property (CHK_VALID && CHK_TYPE == 2'h0
        |=> !FAULT_LOAD && !FAULT_STORE) else $error("fetch wrong fault");
    load_only_a: assert property (CHK_VALID && CHK_TYPE == 2'h1
        |=> !FAULT_FETCH && !FAULT_STORE) else $error("load wrong fault");
    store_only_a: assert property (CHK_VALID && CHK_TYPE == 2'h2
        |=> !FAULT_FETCH && !FAULT_LOAD) else $error("store wrong fault");
    idle_quiet_a: assert property (!CHK_VALID
        |=> !(FAULT_FETCH || FAULT_LOAD || FAULT_STORE))
        else $error("fault without request");
endmodule // pmg_monitor

bind pmg_regs pmg_monitor #(.XW(XW)) u_mon (.CLK(CLK), .NRST(NRST),
    .REG_EN(REG_EN), .REG_SEL(REG_SEL), .REG_IDX(REG_IDX),
    .REG_PRV(REG_PRV), .REG_RDATA(REG_RDATA), .REG_ILLEGAL(REG_ILLEGAL),
    .CHK_VALID(CHK_VALID), .CHK_TYPE(CHK_TYPE), .FAULT_FETCH(FAULT_FETCH),
    .FAULT_LOAD(FAULT_LOAD), .FAULT_STORE(FAULT_STORE));

/* tb/pmg_hart.sv */
// hart access path model: presents check requests to the guard
module pmg_hart (
    input  wire [41:0] req,
    input  wire        vld,
    output wire        c_vld,
    output wire [33:0] c_addr,
    output wire [3:0]  c_size,
    output wire [1:0]  c_typ,
    output wire [1:0]  c_prv
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle lines show the inverse so stale values never look valid
    wire [41:0] bus = vld ? req : ~req;
    assign c_vld = vld;
    assign {c_addr, c_size} = bus[41:4];
    assign c_typ = bus[3:2];
    assign c_prv = bus[1:0];
endmodule // pmg_hart

/* tb/tb.sv */
// self-checking bench for the memory guard register set
`include "pmg_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg CLK = 0, NRST = 0, REG_EN = 0, REG_WE = 0, REG_SEL = 0, h_vld = 0;
    reg  [5:0]  REG_IDX = 0;
    reg  [31:0] REG_WDATA = 0;
    reg  [1:0]  REG_PRV = 0;
    reg  [41:0] h_req = 0;
    wire [31:0] REG_RDATA;
    wire REG_ILLEGAL, FAULT_FETCH, FAULT_LOAD, FAULT_STORE, c_vld;
    wire [33:0] c_addr;
    wire [3:0]  c_size;
    wire [1:0]  c_typ, c_prv;
    integer fails = 0, tests_run = 0, cyc = 0;
    pmg_hart u_hart (.req(h_req), .vld(h_vld), .c_vld(c_vld),
        .c_addr(c_addr), .c_size(c_size), .c_typ(c_typ), .c_prv(c_prv));
    pmg_regs #(.NENT(16), .XW(32), .G(0)) u_dut (.CLK(CLK), .NRST(NRST),
        .REG_EN(REG_EN), .REG_WE(REG_WE), .REG_SEL(REG_SEL),
        .REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .REG_PRV(REG_PRV),
        .REG_RDATA(REG_RDATA), .REG_ILLEGAL(REG_ILLEGAL),
        .CHK_VALID(c_vld), .CHK_ADDR(c_addr), .CHK_SIZE(c_size),
        .CHK_TYPE(c_typ), .CHK_PRV(c_prv), .FAULT_FETCH(FAULT_FETCH),
        .FAULT_LOAD(FAULT_LOAD), .FAULT_STORE(FAULT_STORE));
    always #20 CLK = ~CLK;
    task cmp(input string n, input [31:0] e, input [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task cmp_f(input [2:0] e);
        cmp("fault", {29'h0, e}, {29'h0, FAULT_FETCH, FAULT_LOAD, FAULT_STORE});
    endtask
    task acc(input w, input s, input [5:0] i, input [31:0] d, input [1:0] p);
        @(posedge CLK);
        REG_EN <= 1'b1;
        {REG_WE, REG_SEL, REG_IDX, REG_WDATA, REG_PRV} <= {w, s, i, d, p};
        @(posedge CLK);
        REG_EN <= 1'b0;
        #1;
    endtask
    task rd(input s, input [5:0] i, input [1:0] p, input [31:0] e);
        acc(1'b0, s, i, 32'h0, p);
        cmp("rdata", e, REG_RDATA);
    endtask
    task chk(input [33:0] a, input [3:0] z, input [1:0] t, input [1:0] p,
             input [2:0] e);
        @(posedge CLK);
        h_vld <= 1'b1;
        h_req <= {a, z, t, p};
        @(posedge CLK);
        h_vld <= 1'b0;
        #1;
        cmp_f(e);
    endtask
    task t_setup;
        rd(1'b0, 6'd0, `PMG_PRV_M, 32'h0);
        acc(1'b1, 1'b1, 6'd1, 32'h41, `PMG_PRV_M);
        acc(1'b1, 1'b1, 6'd2, 32'h80, `PMG_PRV_M);
        acc(1'b1, 1'b0, 6'd0, 32'h60091b02, `PMG_PRV_M);
        rd(1'b0, 6'd0, `PMG_PRV_M, 32'h00091b00);
        rd(1'b1, 6'd1, `PMG_PRV_M, 32'h41);
        acc(1'b1, 1'b1, 6'd0, 32'hffffffff, `PMG_PRV_M);
        rd(1'b1, 6'd0, `PMG_PRV_M, 32'hffffffff);
        $display("test setup done");
    endtask
    task t_refuse;
        rd(1'b0, 6'd16, `PMG_PRV_M, 32'h0);
        cmp("illegal", 32'h1, {31'h0, REG_ILLEGAL});
        acc(1'b1, 1'b1, 6'd1, 32'h0, `PMG_PRV_U);
        cmp("illegal", 32'h1, {31'h0, REG_ILLEGAL});
        rd(1'b1, 6'd1, `PMG_PRV_S, 32'h0);
        rd(1'b1, 6'd1, `PMG_PRV_M, 32'h41);
        $display("test refuse done");
    endtask
    task t_match;
        chk(34'h104, 4'd4, `PMG_ACC_LOAD, `PMG_PRV_U, 3'b000);
        chk(34'h104, 4'd4, `PMG_ACC_FETCH, `PMG_PRV_U, 3'b100);
        chk(34'h108, 4'd4, `PMG_ACC_STORE, `PMG_PRV_U, 3'b000);
        chk(34'h10c, 4'd8, `PMG_ACC_LOAD, `PMG_PRV_U, 3'b010);
        chk(34'h150, 4'd4, `PMG_ACC_LOAD, `PMG_PRV_S, 3'b000);
        chk(34'h150, 4'd4, `PMG_ACC_STORE, `PMG_PRV_U, 3'b001);
        chk(34'h200, 4'd4, `PMG_ACC_LOAD, `PMG_PRV_U, 3'b010);
        chk(34'h000, 4'd4, `PMG_ACC_FETCH, `PMG_PRV_U, 3'b100);
        chk(34'h200, 4'd4, `PMG_ACC_LOAD, `PMG_PRV_M, 3'b000);
        chk(34'h104, 4'd4, `PMG_ACC_FETCH, `PMG_PRV_M, 3'b000);
        $display("test match done");
    endtask
    task t_lock;
        acc(1'b1, 1'b0, 6'd0, 32'h00891b00, `PMG_PRV_M);
        acc(1'b1, 1'b1, 6'd1, 32'h55, `PMG_PRV_M);
        acc(1'b1, 1'b1, 6'd2, 32'h10, `PMG_PRV_M);
        rd(1'b1, 6'd1, `PMG_PRV_M, 32'h41);
        rd(1'b1, 6'd2, `PMG_PRV_M, 32'h80);
        chk(34'h150, 4'd4, `PMG_ACC_FETCH, `PMG_PRV_M, 3'b100);
        chk(34'h150, 4'd4, `PMG_ACC_LOAD, `PMG_PRV_M, 3'b000);
        $display("test lock done");
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fails = fails + 1;
            final_report;
        end
    end
    initial begin
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        t_setup;
        t_refuse;
        t_match;
        t_lock;
        final_report;
    end
endmodule // tb
